//--- logic/shsm_sense_hold.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps

// What this block does
// - Hold mode keeps sense output after switch-off
// - Capture latest sensed current at each switch-off
// - Strobe goes high at switch-off in hold
// - Sense valid only after strobe falls
// - Selection change: discard held, then track new
// - Off channel loses held value on switch
// - Offset polarity bit adds or subtracts offset
// - Held value uses polarity at switch-off
// - Polarity change while off leaves output
// - Set prewarning flag when temperature is high in normal mode
// - Flag clears on read after cooling only
// - Status shows both channel states live
// - Channel bit high when output above half
// - Strobe low once valid until switch-off
// - Two select bits route channel or temperature
module shsm_sense_hold (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic      [31:0]          prdata,
  // Switch control and analog front end
  input  wire logic [1:0]           ch_on_cmd,
  input  wire logic                 normal_mode,
  input  wire shsm_pkg::shsm_analog_s analog,
  input  wire logic [1:0]           out_above_half,
  input  wire logic [1:0]           sense_settled,
  input  wire logic                 temp_over,
  // Sense output side
  output logic      [11:0]          sense_out,
  output logic                      sense_strobe,
  output logic                      held_valid,
  output logic                      irq
);

  localparam int unsigned NA = 5;

  logic [NA-1:0] s1_q, s2_q, s3_q, lv_q, lv_d;
  logic [2:0]    gcr_q, gcr_d;
  logic [1:0]    ofp_q, ofp_d;
  logic          prewarn_q, prewarn_d;
  logic [1:0]    irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
  logic [31:0]   prdata_q, prdata_d, rmux;
  logic          hit;
  logic [1:0]    on_prev_q, sel_prev_q;
  shsm_pkg::shsm_state_e state_q, state_d;
  logic [11:0]   held_q, held_d, sense_q, sense_d, live, raw;
  logic          hv_q, hv_d, strobe_q, strobe_d;
  logic          setup, access, wr, rd, fault_rd;
  logic          hold_en, is_ch, ch, on, on_prev, on_fall, on_rise;
  logic          sel_chg, capture, settled, hot;
  logic [1:0]    out_st;
  shsm_pkg::shsm_sel_e sel;

  // Asynchronous levels: three stages, accepted when stages two and three agree
  always_comb begin
    lv_d = lv_q;
    for (int i = 0; i < NA; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lv_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lv_q <= '0;
    end else begin
      s1_q <= {temp_over, sense_settled, out_above_half};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lv_q <= lv_d;
    end
  end

  assign out_st = lv_q[1:0];
  assign hot    = lv_q[4];

  // APB decode; zero wait states
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign wr       = access & pwrite;
  assign rd       = access & ~pwrite;
  assign fault_rd = rd & (paddr == shsm_pkg::OFS_FAULT);
  assign pready   = 1'b1;
  assign pslverr  = access & ~hit;
  assign prdata   = prdata_q;

  always_comb begin
    rmux = '0;
    hit  = 1'b1;
    if (paddr == shsm_pkg::OFS_GCR) begin
      rmux[2:0] = gcr_q;
    end else if (paddr == shsm_pkg::OFS_RETRY0) begin
      rmux[shsm_pkg::OFP_BIT] = ofp_q[0];
    end else if (paddr == shsm_pkg::OFS_RETRY1) begin
      rmux[shsm_pkg::OFP_BIT] = ofp_q[1];
    end else if (paddr == shsm_pkg::OFS_FAULT) begin
      rmux[shsm_pkg::PREWARN_BIT] = prewarn_q;
    end else if (paddr == shsm_pkg::OFS_STATUS) begin
      rmux[shsm_pkg::CH0_STATE_BIT] = out_st[0];
      rmux[shsm_pkg::CH1_STATE_BIT] = out_st[1];
    end else if (paddr == shsm_pkg::OFS_IRQ_STAT) begin
      rmux[1:0] = irq_stat_q;
    end else if (paddr == shsm_pkg::OFS_IRQ_CLR) begin
      rmux = '0;
    end else if (paddr == shsm_pkg::OFS_IRQ_EN) begin
      rmux[1:0] = irq_en_q;
    end else begin
      hit = 1'b0;
    end
  end

  // Register file next state
  always_comb begin
    gcr_d      = gcr_q;
    ofp_d      = ofp_q;
    irq_en_d   = irq_en_q;
    prdata_d   = prdata_q;
    if (setup && !pwrite) begin
      prdata_d = rmux;
    end
    if (wr && paddr == shsm_pkg::OFS_GCR) begin
      gcr_d = pwdata[2:0];
    end
    if (wr && paddr == shsm_pkg::OFS_RETRY0) begin
      ofp_d[0] = pwdata[shsm_pkg::OFP_BIT];
    end
    if (wr && paddr == shsm_pkg::OFS_RETRY1) begin
      ofp_d[1] = pwdata[shsm_pkg::OFP_BIT];
    end
    if (wr && paddr == shsm_pkg::OFS_IRQ_EN) begin
      irq_en_d = pwdata[1:0];
    end
    // The read clear applies only when not hot, so a hot read never drops it, in or out of normal mode
    prewarn_d = (normal_mode & hot) | (prewarn_q & ~(fault_rd & ~hot));
    irq_stat_d = irq_stat_q;
    if (wr && paddr == shsm_pkg::OFS_IRQ_CLR) begin
      irq_stat_d = irq_stat_q & ~pwdata[1:0];
    end
    if (normal_mode && hot && !prewarn_q) begin
      irq_stat_d[shsm_pkg::IRQ_PREWARN_BIT] = 1'b1;
    end
    if (capture) begin
      irq_stat_d[shsm_pkg::IRQ_CAPTURE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gcr_q      <= shsm_pkg::GCR_RST;
      ofp_q      <= shsm_pkg::OFP_RST;
      irq_en_q   <= shsm_pkg::IRQ_EN_RST;
      irq_stat_q <= '0;
      prewarn_q  <= 1'b0;
      prdata_q   <= '0;
    end else begin
      gcr_q      <= gcr_d;
      ofp_q      <= ofp_d;
      irq_en_q   <= irq_en_d;
      irq_stat_q <= irq_stat_d;
      prewarn_q  <= prewarn_d;
      prdata_q   <= prdata_d;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // Sense route and offset polarity
  assign sel     = shsm_pkg::shsm_sel_e'(gcr_q[1:0]);
  assign hold_en = gcr_q[shsm_pkg::GCR_HOLD_BIT];
  assign is_ch   = (sel == shsm_pkg::SHSM_SEL_CH0) || (sel == shsm_pkg::SHSM_SEL_CH1);
  assign ch      = (sel == shsm_pkg::SHSM_SEL_CH1);
  assign on      = is_ch & ch_on_cmd[ch];
  assign on_prev = is_ch & on_prev_q[ch];
  assign on_fall = on_prev & ~on;
  assign on_rise = ~on_prev & on;
  assign settled = lv_q[2 + 32'(ch)];
  assign sel_chg = (gcr_q[1:0] != sel_prev_q);
  assign raw     = ch ? analog.ch1_code : analog.ch0_code;
  // Wraps rather than saturates; the offset term is small against full scale
  assign live    = ofp_q[ch] ? raw + analog.offset_code
                             : raw - analog.offset_code;

  assign capture = hold_en && is_ch && !sel_chg && on_fall && (state_q == shsm_pkg::SHSM_TRACK);

  // Track and hold sequencing
  always_comb begin
    state_d = state_q;
    held_d  = held_q;
    hv_d    = hv_q;
    case (state_q)
      shsm_pkg::SHSM_TRACK: begin
        if (hold_en && sel_chg) begin
          state_d = shsm_pkg::SHSM_FLUSH;
        end else if (capture) begin
          state_d = shsm_pkg::SHSM_HOLD;
          held_d  = live;
          hv_d    = 1'b1;
        end
      end
      shsm_pkg::SHSM_HOLD: begin
        // Polarity writes while off do not touch held_q
        if (sel_chg) begin
          state_d = shsm_pkg::SHSM_FLUSH;
        end else if (on_rise || !hold_en) begin
          state_d = shsm_pkg::SHSM_TRACK;
          hv_d    = 1'b0;
        end
      end
      default: begin
        state_d = shsm_pkg::SHSM_TRACK;
        held_d  = shsm_pkg::SENSE_RST;
        hv_d    = 1'b0;
      end
    endcase
    if (state_d == shsm_pkg::SHSM_FLUSH) begin
      held_d = shsm_pkg::SENSE_RST;
      hv_d   = 1'b0;
    end
  end

  // Output value and strobe, registered from state_d so they change together with state_q
  always_comb begin
    if (sel == shsm_pkg::SHSM_SEL_TEMP) begin
      sense_d = analog.temp_code;
    end else if (state_d == shsm_pkg::SHSM_HOLD) begin
      sense_d = held_d;
    end else if (state_d == shsm_pkg::SHSM_TRACK && on) begin
      sense_d = live;
    end else begin
      sense_d = shsm_pkg::SENSE_RST;
    end
    // Low only while the tracked channel is on and settled
    strobe_d = !(on && settled && state_d == shsm_pkg::SHSM_TRACK);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= shsm_pkg::SHSM_TRACK;
      held_q     <= shsm_pkg::SENSE_RST;
      hv_q       <= 1'b0;
      sense_q    <= shsm_pkg::SENSE_RST;
      strobe_q   <= 1'b1;
      on_prev_q  <= '0;
      sel_prev_q <= '0;
    end else begin
      state_q    <= state_d;
      held_q     <= held_d;
      hv_q       <= hv_d;
      sense_q    <= sense_d;
      strobe_q   <= strobe_d;
      on_prev_q  <= ch_on_cmd;
      sel_prev_q <= gcr_q[1:0];
    end
  end

  assign sense_out    = sense_q;
  assign sense_strobe = strobe_q;
  assign held_valid   = hv_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hold_capture_a: assert property (capture |=> (sense_out == $past(live)) && held_valid)
    else $error("held value not captured at switch-off");

  hold_keeps_a: assert property ((state_q == shsm_pkg::SHSM_HOLD) && !sel_chg && !on_rise
    && hold_en && sel != shsm_pkg::SHSM_SEL_TEMP |=> $stable(sense_out))
    else $error("held output changed while off");

  ofp_ignored_a: assert property ((state_q == shsm_pkg::SHSM_HOLD) && $changed(ofp_q)
    && !sel_chg && !on_rise && hold_en |-> $stable(held_q))
    else $error("polarity change altered held value");

  strobe_off_a: assert property (hold_en && on_fall |=> sense_strobe)
    else $error("strobe not high at switch-off");

  strobe_low_a: assert property (on && settled && !sel_chg && state_q == shsm_pkg::SHSM_TRACK
    && !hold_en ##1 on && !sel_chg |-> !sense_strobe)
    else $error("strobe not low while valid");

  flush_seq_a: assert property (hold_en && sel_chg && state_q != shsm_pkg::SHSM_FLUSH
    |=> state_q == shsm_pkg::SHSM_FLUSH && !held_valid ##1 state_q == shsm_pkg::SHSM_TRACK)
    else $error("selection change did not flush held value");

  prewarn_set_a: assert property (normal_mode && hot |=> prewarn_q)
    else $error("prewarning flag not set");

  prewarn_keep_a: assert property (prewarn_q && fault_rd && hot |=> prewarn_q)
    else $error("prewarning flag cleared while hot");

  prewarn_clr_a: assert property (prewarn_q && fault_rd && !hot
    |=> !prewarn_q)
    else $error("prewarning flag not cleared by read");

  polarity_a: assert property (on && state_q == shsm_pkg::SHSM_TRACK && state_d == state_q
    && sel != shsm_pkg::SHSM_SEL_TEMP |=> sense_out == ($past(ofp_q[ch])
    ? $past(raw) + $past(analog.offset_code) : $past(raw) - $past(analog.offset_code)))
    else $error("offset polarity not applied");

endmodule // shsm_sense_hold

//--- logic/shsm_pkg.sv
package shsm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_GCR      = 8'h00;
  localparam logic [7:0] OFS_RETRY0   = 8'h04;
  localparam logic [7:0] OFS_RETRY1   = 8'h08;
  localparam logic [7:0] OFS_FAULT    = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h1C;

  // Field positions
  localparam int unsigned GCR_SEL0_BIT    = 0;
  localparam int unsigned GCR_SEL1_BIT    = 1;
  localparam int unsigned GCR_HOLD_BIT    = 2;
  localparam int unsigned OFP_BIT         = 8;
  localparam int unsigned PREWARN_BIT     = 8;
  localparam int unsigned CH0_STATE_BIT   = 0;
  localparam int unsigned CH1_STATE_BIT   = 1;
  localparam int unsigned IRQ_PREWARN_BIT = 0;
  localparam int unsigned IRQ_CAPTURE_BIT = 1;

  // Widths and reset values
  localparam int unsigned CODE_W      = 12;
  localparam logic [2:0]  GCR_RST     = 3'h0;
  localparam logic [1:0]  OFP_RST     = 2'h0;
  localparam logic [1:0]  IRQ_EN_RST  = 2'h0;
  localparam logic [11:0] SENSE_RST   = 12'h000;

  // Sense route, from the two select bits
  typedef enum logic [1:0] {
    SHSM_SEL_NONE, SHSM_SEL_CH0, SHSM_SEL_CH1, SHSM_SEL_TEMP
  } shsm_sel_e;

  typedef enum logic [1:0] {SHSM_TRACK, SHSM_HOLD, SHSM_FLUSH} shsm_state_e;

  // Converted sense quantities, all on pclk
  typedef struct packed {
    logic [11:0] ch0_code;
    logic [11:0] ch1_code;
    logic [11:0] temp_code;
    logic [11:0] offset_code;
  } shsm_analog_s;

endpackage

//--- bench/shsm_mcu_model.sv
`timescale 1ns/1ps

module shsm_mcu_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Sense pins
  input  wire logic [11:0] sense_out,
  input  wire logic        sense_strobe,
  // Mean of the last two samples
  output logic      [11:0] avg_code
);
  logic        strobe_q;
  logic [11:0] smp_a_q;
  logic [11:0] smp_b_q;
  logic [12:0] sum;

  assign sum      = {1'b0, smp_a_q} + {1'b0, smp_b_q};
  assign avg_code = sum[12:1];

  // Sampled only after the strobe falls, so settling values never enter the mean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_q <= 1'b1;
      smp_a_q  <= 12'h000;
      smp_b_q  <= 12'h000;
    end else begin
      strobe_q <= sense_strobe;
      if (strobe_q && !sense_strobe) begin
        smp_a_q <= smp_b_q;
        smp_b_q <= sense_out;
      end
    end
  end
endmodule // shsm_mcu_model

//--- bench/sense_hold_and_status_monitor_tb.sv
`timescale 1ns/1ps

module sense_hold_and_status_monitor_tb;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0, prdata, rd;
  logic                   pready, pslverr, sense_strobe, held_valid, irq;
  logic [1:0]             ch_on_cmd = 2'h0, out_above_half = 2'h0, sense_settled = 2'h0;
  logic                   normal_mode = 1'b0, temp_over = 1'b0;
  logic [11:0]            sense_out, avg_code;
  logic [11:0]            exp_sel [4] = '{12'h000, 12'h3D0, 12'h270, 12'h155};
  shsm_pkg::shsm_analog_s analog = '{12'h400, 12'h2A0, 12'h155, 12'h030};
  int                     err_total = 0, n_checks = 0;

  always #2 pclk = ~pclk;

  shsm_sense_hold uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .ch_on_cmd(ch_on_cmd), .normal_mode(normal_mode), .analog(analog),
    .out_above_half(out_above_half), .sense_settled(sense_settled), .temp_over(temp_over),
    .sense_out(sense_out), .sense_strobe(sense_strobe), .held_valid(held_valid), .irq(irq));

  shsm_mcu_model mcu (.pclk(pclk), .presetn(presetn), .sense_out(sense_out),
    .sense_strobe(sense_strobe), .avg_code(avg_code));

  task conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      conclude();
    end
    rd = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task ch(input logic [1:0] on);
    @(posedge pclk);
    ch_on_cmd     <= on;
    sense_settled <= on;
  endtask

  task nwait(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task wait_strobe(input logic lvl);
    int n;
    n = 0;
    while (sense_strobe !== lvl && n < 20) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 20) begin
      err_total++;
      conclude();
    end
  endtask

  task t_regs();
    rchk("gcr reset", shsm_pkg::OFS_GCR, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    chk("slverr", {31'h0, slv}, 32'h1);
    rchk("irq clr reads", shsm_pkg::OFS_IRQ_CLR, 32'h0);
    chk("no slverr", {31'h0, slv}, 32'h0);
  endtask

  task t_sync();
    apb(1'b1, shsm_pkg::OFS_GCR, 32'h1);
    ch(2'b11);
    wait_strobe(1'b0);
    nwait(1);
    chk("sync sense", sense_out, 12'h3D0);
    nwait(5);
    chk("strobe low", sense_strobe, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, shsm_pkg::OFS_GCR, i);
      nwait(4);
      chk("route", sense_out, exp_sel[i]);
    end
    apb(1'b1, shsm_pkg::OFS_GCR, 32'h1);
    ch(2'b00);
    wait_strobe(1'b1);
    nwait(2);
    chk("sync off", sense_out, 12'h000);
  endtask

  task t_hold();
    apb(1'b1, shsm_pkg::OFS_RETRY0, 32'h100);
    apb(1'b1, shsm_pkg::OFS_GCR, 32'h5);
    apb(1'b1, shsm_pkg::OFS_IRQ_EN, 32'h2);
    ch(2'b01);
    wait_strobe(1'b0);
    nwait(1);
    chk("track pos", sense_out, 12'h430);
    ch(2'b00);
    nwait(3);
    chk("held", held_valid, 1'b1);
    chk("off strobe", sense_strobe, 1'b1);
    chk("captured", sense_out, 12'h430);
    chk("irq on", irq, 1'b1);
    apb(1'b1, shsm_pkg::OFS_RETRY0, 32'h0);
    analog.ch0_code <= 12'h7FF;
    nwait(3);
    chk("held stays", sense_out, 12'h430);
    apb(1'b1, shsm_pkg::OFS_IRQ_EN, 32'h0);
    nwait(1);
    chk("irq masked", irq, 1'b0);
    rchk("irq stat", shsm_pkg::OFS_IRQ_STAT, 32'h2);
    apb(1'b1, shsm_pkg::OFS_IRQ_CLR, 32'h2);
    rchk("irq cleared", shsm_pkg::OFS_IRQ_STAT, 32'h0);
    analog.ch0_code <= 12'h400;
    ch(2'b01);
    nwait(2);
    chk("rearm", held_valid, 1'b0);
    wait_strobe(1'b0);
    nwait(2);
    chk("track neg", sense_out, 12'h3D0);
    chk("mean", avg_code, 12'h400);
    ch(2'b00);
    nwait(3);
    apb(1'b1, shsm_pkg::OFS_GCR, 32'h6);
    nwait(2);
    chk("flush", held_valid, 1'b0);
    apb(1'b1, shsm_pkg::OFS_GCR, 32'h5);
    nwait(2);
    chk("lost", held_valid, 1'b0);
  endtask

  task t_warn();
    @(posedge pclk);
    temp_over <= 1'b1;
    nwait(6);
    rchk("no warn", shsm_pkg::OFS_FAULT, 32'h0);
    @(posedge pclk);
    normal_mode <= 1'b1;
    nwait(6);
    rchk("warn", shsm_pkg::OFS_FAULT, 32'h100);
    rchk("warn hot", shsm_pkg::OFS_FAULT, 32'h100);
    temp_over <= 1'b0;
    nwait(6);
    rchk("warn cool", shsm_pkg::OFS_FAULT, 32'h100);
    rchk("warn gone", shsm_pkg::OFS_FAULT, 32'h0);
    // Capture bit is set again by the last switch-off of the hold scenario
    rchk("warn event", shsm_pkg::OFS_IRQ_STAT, 32'h3);
  endtask

  task t_state();
    out_above_half <= 2'b10;
    nwait(6);
    rchk("state ch1", shsm_pkg::OFS_STATUS, 32'h2);
    @(posedge pclk);
    out_above_half <= 2'b01;
    nwait(6);
    rchk("state ch0", shsm_pkg::OFS_STATUS, 32'h1);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sync();
    t_hold();
    t_warn();
    t_state();
    conclude();
  end
endmodule // sense_hold_and_status_monitor_tb
